/* core/dlr_top.sv */
// Display link lane 0 receiver with turnaround and the module reset filter.
// Assumes the link pins arrive unsynchronised; the link clock is sampled as data.
`timescale 1ns/100ps
module dlr_top #(
    parameter int unsigned DONE_SLPIN_CYC = dlr_pkg::DONE_SLPIN_CYC,
    parameter int unsigned DONE_SLPOUT_CYC = dlr_pkg::DONE_SLPOUT_CYC,
    parameter int unsigned OTP_LOAD_CYC = dlr_pkg::OTP_LOAD_CYC,
    parameter int unsigned OTP_WIDTH = 16
) (
    // Clock and reset.
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    // Module reset pin, active low.
    input wire logic RESET_IN_LOW_N_I,
    // Mode and one-time memory.
    input wire logic SLEEP_OUT_I,
    input wire logic [OTP_WIDTH-1:0] OTP_DATA_I,
    // Link pins: clock lane sampled, lane 0 low-power and high-speed data.
    input wire logic CLK_LANE_LP_P_I,
    input wire logic CLK_LANE_LP_N_I,
    input wire logic CLK_LANE_HS_I,
    input wire logic D0_LP_P_I,
    input wire logic D0_LP_N_I,
    input wire logic D0_HS_I,
    // Lane 0 low-power drive during turnaround.
    output logic D0_LP_P_O,
    output logic D0_LP_N_O,
    output logic D0_LP_OE_O,
    // Termination enables.
    output logic CLK_TERM_EN_O,
    output logic D0_TERM_EN_O,
    // Received bytes.
    output logic RX_VALID_O,
    input wire logic RX_READY_I,
    output logic [7:0] RX_DATA_O,
    output logic RX_OVERRUN_O,
    // Reset status.
    output logic RESET_BUSY_O,
    output logic BLANK_O,
    output logic [OTP_WIDTH-1:0] OTP_REG_O
);
    // Two-flop synchronisers for the reset pin and every link pin.
    logic [6:0] s1_r;
    logic [6:0] s2_r;
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            // Idle levels: reset pin and LP lines high, link clock and data low, so no false edge follows.
            s1_r <= 7'h76;
            s2_r <= 7'h76;
        end
        else
        begin
            s1_r <= {RESET_IN_LOW_N_I, CLK_LANE_LP_P_I, CLK_LANE_LP_N_I, CLK_LANE_HS_I,
                     D0_LP_P_I, D0_LP_N_I, D0_HS_I};
            s2_r <= s1_r;
        end
    end
    logic rst_pin;
    logic [1:0] clk_lp;
    logic clk_hs;
    logic [1:0] d0_lp;
    logic d0_hs;
    assign rst_pin = s2_r[6];
    assign clk_lp = s2_r[5:4];
    assign clk_hs = s2_r[3];
    assign d0_lp = s2_r[2:1];
    assign d0_hs = s2_r[0];

    // Low-time counter with glitch bridging; short highs inside a low pulse are absorbed once the reset is taken, else they clear the count.
    logic [15:0] low_cnt_r;
    logic [15:0] hi_cnt_r;
    logic in_rst_r;
    logic pulse_go;
    assign pulse_go = (low_cnt_r >= 16'(dlr_pkg::RST_REJECT_CYC));
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            low_cnt_r <= 16'h0;
            hi_cnt_r <= 16'h0;
            in_rst_r <= 1'b0;
        end
        else if (!rst_pin)
        begin
            hi_cnt_r <= 16'h0;
            if (low_cnt_r != 16'hffff)
                low_cnt_r <= low_cnt_r + 16'h1;
            if (pulse_go)
                in_rst_r <= 1'b1;
        end
        else if (hi_cnt_r < 16'(dlr_pkg::RST_GLITCH_CYC))
        begin
            // A short high is a glitch; the low count is held once the reset is taken, else it is cleared.
            hi_cnt_r <= hi_cnt_r + 16'h1;
            if (!in_rst_r)
                low_cnt_r <= 16'h0;
        end
        else
        begin
            low_cnt_r <= 16'h0;
            in_rst_r <= 1'b0;
        end
    end

    // Reset sequencer: busy while the filtered reset is held and until the completion count runs out.
    logic busy_r;
    logic from_slpout_r;
    logic [31:0] done_cnt_r;
    logic [OTP_WIDTH-1:0] otp_r;
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            busy_r <= 1'b1;
            from_slpout_r <= 1'b0;
            done_cnt_r <= 32'h0;
            otp_r <= '0;
        end
        else if (in_rst_r)
        begin
            if (!busy_r)
                from_slpout_r <= SLEEP_OUT_I;
            busy_r <= 1'b1;
            done_cnt_r <= 32'h0;
        end
        else if (busy_r)
        begin
            done_cnt_r <= done_cnt_r + 32'h1;
            if (done_cnt_r == 32'(OTP_LOAD_CYC - 1))
                otp_r <= OTP_DATA_I;
            if (done_cnt_r == 32'((from_slpout_r ? DONE_SLPOUT_CYC : DONE_SLPIN_CYC) - 1))
                busy_r <= 1'b0;
        end
    end
    assign RESET_BUSY_O = busy_r;
    assign BLANK_O = busy_r;
    assign OTP_REG_O = otp_r;

    // While the reset sequencer is not busy, clock lane termination follows the prepare state within one cycle.
    logic clk_term_r;
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            clk_term_r <= 1'b0;
        else if (busy_r || clk_lp == dlr_pkg::LP_11)
            clk_term_r <= 1'b0;
        else if (clk_lp == dlr_pkg::LP_00)
            clk_term_r <= 1'b1;
    end
    assign CLK_TERM_EN_O = clk_term_r;

    // Clock lane edge detection on the sampled high-speed clock.
    logic clk_hs_d_r;
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            clk_hs_d_r <= 1'b0;
        else
            clk_hs_d_r <= clk_hs;
    end
    logic clk_rise;
    assign clk_rise = clk_hs && !clk_hs_d_r;

    // Lane 0 state machine.
    dlr_pkg::dlr_lane_type st_r;
    logic [3:0] tcnt_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic byte_v_r;
    logic [7:0] byte_r;
    logic buf_ready;
    logic ovr_r;
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            st_r <= dlr_pkg::DLR_STOP;
            tcnt_r <= 4'h0;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h0;
            byte_v_r <= 1'b0;
            byte_r <= 8'h0;
            ovr_r <= 1'b0;
        end
        else
        begin
            byte_v_r <= 1'b0;
            if (busy_r)
            begin
                st_r <= dlr_pkg::DLR_STOP;
                ovr_r <= 1'b0;
            end
            else
            begin
                // Overrun is judged when the byte meets the buffer, so a pop in that cycle does not make room for it.
                if (byte_v_r && !buf_ready)
                    ovr_r <= 1'b1;
                unique case (st_r)
                    dlr_pkg::DLR_STOP:
                    begin
                        if (d0_lp == dlr_pkg::LP_01)
                            st_r <= dlr_pkg::DLR_HS_RQST;
                        else if (d0_lp == dlr_pkg::LP_10)
                            st_r <= dlr_pkg::DLR_TA_RQST;
                    end
                    dlr_pkg::DLR_HS_RQST:
                    begin
                        if (d0_lp == dlr_pkg::LP_00)
                            st_r <= dlr_pkg::DLR_PREP;
                        else if (d0_lp == dlr_pkg::LP_11)
                            st_r <= dlr_pkg::DLR_STOP;
                    end
                    dlr_pkg::DLR_PREP:
                    begin
                        bit_cnt_r <= 3'h0;
                        // Leader bit of the sync pattern starts data.
                        if (clk_rise && d0_hs)
                            st_r <= dlr_pkg::DLR_HS;
                        else if (d0_lp == dlr_pkg::LP_11)
                            st_r <= dlr_pkg::DLR_STOP;
                    end
                    dlr_pkg::DLR_HS:
                    begin
                        if (d0_lp == dlr_pkg::LP_11)
                        begin
                            st_r <= dlr_pkg::DLR_SKIP;
                            tcnt_r <= 4'h0;
                        end
                        else if (clk_rise)
                        begin
                            shift_r <= {d0_hs, shift_r[7:1]};
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == 3'h7)
                            begin
                                byte_r <= {d0_hs, shift_r[7:1]};
                                byte_v_r <= 1'b1;
                            end
                        end
                    end
                    dlr_pkg::DLR_SKIP:
                    begin
                        // Line activity is ignored while the window runs.
                        tcnt_r <= tcnt_r + 4'h1;
                        if (tcnt_r == 4'(dlr_pkg::HS_SKIP_CYC - 1))
                            st_r <= dlr_pkg::DLR_STOP;
                    end
                    dlr_pkg::DLR_TA_RQST:
                    begin
                        tcnt_r <= 4'h0;
                        if (d0_lp == dlr_pkg::LP_00)
                            st_r <= dlr_pkg::DLR_TA_DRIVE;
                        else if (d0_lp == dlr_pkg::LP_11)
                            st_r <= dlr_pkg::DLR_STOP;
                    end
                    dlr_pkg::DLR_TA_DRIVE:
                    begin
                        // One state per cycle: 50 ns sits in the 50 to 75 ns window.
                        tcnt_r <= tcnt_r + 4'h1;
                        if (tcnt_r == 4'(dlr_pkg::TA_GET_LPX * dlr_pkg::TA_LPX_CYC + 1))
                            st_r <= dlr_pkg::DLR_STOP;
                    end
                endcase
            end
        end
    end

    // Turnaround drive: LP-00 for five periods, then LP-10 and LP-11 before release.
    always_comb
    begin
        D0_LP_OE_O = (st_r == dlr_pkg::DLR_TA_DRIVE);
        D0_LP_P_O = 1'b0;
        D0_LP_N_O = 1'b0;
        if (st_r == dlr_pkg::DLR_TA_DRIVE && tcnt_r >= 4'(dlr_pkg::TA_GET_LPX))
        begin
            D0_LP_P_O = 1'b1;
            D0_LP_N_O = (tcnt_r > 4'(dlr_pkg::TA_GET_LPX));
        end
    end
    assign D0_TERM_EN_O = (st_r == dlr_pkg::DLR_HS);
    assign RX_OVERRUN_O = ovr_r;

    // Bytes pass a two-entry buffer so a receiver stall loses nothing queued.
    dlr_buf2 #(.WIDTH(8)) u_buf (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .in_valid_i(byte_v_r),
        .in_ready_o(buf_ready),
        .in_data_i(byte_r),
        .out_valid_o(RX_VALID_O),
        .out_ready_i(RX_READY_I),
        .out_data_o(RX_DATA_O)
    );

    // Checks on reset filter, sequencer, clock termination, skip window and turnaround.
    short_pulse_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        $rose(in_rst_r) |-> $past(low_cnt_r) >= 16'(dlr_pkg::RST_REJECT_CYC))
        else $error("Reset taken from a pulse below the reject length.");
    long_pulse_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        low_cnt_r == 16'(dlr_pkg::RST_ACCEPT_CYC) |-> ##1 in_rst_r)
        else $error("Long reset pulse not accepted.");
    blank_busy_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        in_rst_r |-> ##1 (BLANK_O && RESET_BUSY_O))
        else $error("Display not blanked during reset.");
    otp_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        busy_r && !in_rst_r && done_cnt_r == 32'(OTP_LOAD_CYC - 1) |=> OTP_REG_O == $past(OTP_DATA_I))
        else $error("One-time memory not loaded in time.");
    done_in_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        busy_r && !from_slpout_r |-> done_cnt_r < 32'(DONE_SLPIN_CYC))
        else $error("Sleep-in reset overran its completion time.");
    done_out_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        busy_r |-> done_cnt_r < 32'(DONE_SLPOUT_CYC))
        else $error("Sleep-out reset overran its completion time.");
    clk_term_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        !busy_r && clk_lp == dlr_pkg::LP_00 |=> CLK_TERM_EN_O)
        else $error("Clock termination late.");
    ta_low_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        $rose(D0_LP_OE_O) |-> (D0_LP_OE_O && !D0_LP_P_O && !D0_LP_N_O) [*5])
        else $error("Turnaround both-low too short.");
    skip_win_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        $rose(st_r == dlr_pkg::DLR_SKIP) && !busy_r |=> st_r == dlr_pkg::DLR_STOP || busy_r)
        else $error("Skip window length wrong.");
    glitch_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        in_rst_r && rst_pin && hi_cnt_r < 16'(dlr_pkg::RST_GLITCH_CYC) |=> in_rst_r)
        else $error("Glitch ended a valid reset.");
    reset_c: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) $fell(busy_r));
    burst_c: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) RX_VALID_O && RX_READY_I);
    ta_c: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) $fell(D0_LP_OE_O));
    stall_c: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) byte_v_r && !buf_ready);

endmodule : dlr_top

/* include/dlr_pkg.sv */
// Package holding constants for the display link lane receiver and reset filter.
// Assumes a single 20 MHz system clock drives every user of these constants.
package dlr_pkg;

    // System clock period in ns.
    localparam int unsigned CLK_PERIOD_NS = 50;

    // Reset pulse filter thresholds in ns.
    localparam int unsigned RST_REJECT_NS = 5000;
    localparam int unsigned RST_ACCEPT_NS = 10000;
    // A shorter pulse is dropped, so the least figure rounds up.
    localparam int unsigned RST_REJECT_CYC = (RST_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // A longer pulse always resets, so the longest figure rounds down.
    localparam int unsigned RST_ACCEPT_CYC = RST_ACCEPT_NS / CLK_PERIOD_NS;
    // Glitch tolerated inside a valid low pulse, in cycles.
    localparam int unsigned RST_GLITCH_CYC = RST_REJECT_CYC;

    // Reset completion limits in ms.
    localparam int unsigned DONE_SLPIN_MS = 5;
    localparam int unsigned DONE_SLPOUT_MS = 120;
    localparam int unsigned OTP_LOAD_MS = 5;
    localparam int unsigned DONE_SLPIN_CYC = DONE_SLPIN_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned DONE_SLPOUT_CYC = DONE_SLPOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned OTP_LOAD_CYC = OTP_LOAD_MS * 1000000 / CLK_PERIOD_NS;

    // End-of-burst skip window, least value in ns.
    localparam int unsigned HS_SKIP_NS = 40;
    localparam int unsigned HS_SKIP_CYC = (HS_SKIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Clock lane termination enable, latest value in ns.
    localparam int unsigned TERM_EN_NS = 38;
    localparam int unsigned TERM_EN_CYC = (TERM_EN_NS / CLK_PERIOD_NS) < 1 ? 1 : TERM_EN_NS / CLK_PERIOD_NS;
    // Turnaround low-power state length, 50 to 75 ns; one system cycle sits inside.
    localparam int unsigned TA_LPX_NS = 50;
    localparam int unsigned TA_LPX_CYC = (TA_LPX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Device drives both-low for five periods in turnaround.
    localparam int unsigned TA_GET_LPX = 5;

    // Low-power line states, bit1 = positive line, bit0 = negative line.
    localparam logic [1:0] LP_00 = 2'h0;
    localparam logic [1:0] LP_01 = 2'h1;
    localparam logic [1:0] LP_10 = 2'h2;
    localparam logic [1:0] LP_11 = 2'h3;

    // Escape-free data receiver states.
    typedef enum logic [2:0] {
        DLR_STOP, DLR_HS_RQST, DLR_PREP, DLR_HS, DLR_SKIP, DLR_TA_RQST, DLR_TA_DRIVE
    } dlr_lane_type;

endpackage : dlr_pkg

/* core/dlr_buf2.sv */
// Two-entry valid/ready buffer for received bytes.
// Assumes both sides run on the same system clock.
`timescale 1ns/100ps
module dlr_buf2 #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic nrst_i,
    // Fill side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_r [2];
    logic rd_ptr_r;
    logic wr_ptr_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    // Handshakes are plain functions of the fill level.
    assign in_ready_o = (cnt_r != 2'h2);
    assign out_valid_o = (cnt_r != 2'h0);
    assign out_data_o = mem_r[rd_ptr_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointers and fill level.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
            cnt_r <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= ~wr_ptr_r;
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage, written only on an accepted word.
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_data_i;
    end

endmodule : dlr_buf2

/* verif/dlr_host_model.sv */
// Host display controller model: drives the clock lane and lane 0, and turns the bus round.
// Assumes the bench fills tx_q before each burst; timing is in ns, unrelated to the system clock.
`timescale 1ns/100ps
module dlr_host_model (
    // Clock lane.
    output logic clk_lp_p_o,
    output logic clk_lp_n_o,
    output logic clk_hs_o,
    // Lane 0 as seen on the wire.
    output logic d0_lp_p_o,
    output logic d0_lp_n_o,
    output logic d0_hs_o,
    // Device drive of lane 0.
    input wire logic dev_p_i,
    input wire logic dev_n_i,
    input wire logic dev_oe_i
);
    logic [7:0] tx_q[$];
    logic [1:0] hst_r = 2'h3;
    logic hoe_r = 1'b1;
    logic [1:0] last_r = 2'h3;
    logic run_r = 1'b0;

    // The wire shows the driver, or the inverse of the last driven level when nobody drives.
    always @*
    begin
        if (dev_oe_i || hoe_r)
            last_r = dev_oe_i ? {dev_p_i, dev_n_i} : hst_r;
    end
    assign {d0_lp_p_o, d0_lp_n_o} = (dev_oe_i || hoe_r) ? last_r : ~last_r;

    // Idle levels at time zero.
    initial
    begin
        {clk_lp_p_o, clk_lp_n_o} = 2'h3;
        clk_hs_o = 1'b0;
        d0_hs_o = 1'b0;
    end

    // The link clock runs at 400 ns only inside a frame, so the rate stays low.
    always
    begin
        wait (run_r);
        #200 clk_hs_o = 1'b1;
        #200 clk_hs_o = 1'b0;
    end

    // Presents one bit at the link clock's falling edge.
    task automatic hs_bit(input logic b);
    begin
        @(negedge clk_hs_o);
        d0_hs_o = b;
    end
    endtask : hs_bit

    // Sends the queued bytes LSB first after a leader bit, then pad_bits loose bits.
    task automatic send_burst(input int unsigned pad_bits);
        logic [7:0] b;
    begin
        // Lane 0 starts at high-speed zero, so a level left by the last burst is no false leader.
        d0_hs_o = 1'b0;
        {clk_lp_p_o, clk_lp_n_o} = 2'h1;
        #100 {clk_lp_p_o, clk_lp_n_o} = 2'h0;
        #110 run_r = 1'b1;
        repeat (4) @(negedge clk_hs_o);
        hst_r = 2'h1;
        #150 hst_r = 2'h0;
        repeat (2) @(negedge clk_hs_o);
        hs_bit(1'b1);
        while (tx_q.size() > 0)
        begin
            b = tx_q.pop_front();
            for (int i = 0; i < 8; i++)
                hs_bit(b[i]);
        end
        for (int i = 0; i < pad_bits; i++)
            hs_bit(i[0]);
        hs_bit(~d0_hs_o);
        @(negedge clk_hs_o);
        hst_r = 2'h3;
        d0_hs_o = ~d0_hs_o;
        repeat (27) @(negedge clk_hs_o);
        // A fixed wait: the clock may stop without a further falling edge.
        run_r = 1'b0;
        #500 {clk_lp_p_o, clk_lp_n_o} = 2'h3;
        #100;
    end
    endtask : send_burst

    // Requests a turnaround, hands the lane over and takes it back after the device lets go.
    task automatic turn_round();
    begin
        hst_r = 2'h2;
        #150 hst_r = 2'h0;
        #200 hoe_r = 1'b0;
        wait (dev_oe_i);
        wait (!dev_oe_i);
        #60 hst_r = 2'h3;
        hoe_r = 1'b1;
    end
    endtask : turn_round
endmodule : dlr_host_model

/* verif/testbench.sv */
// Self-checking bench for the lane 0 receiver and module reset filter.
// Assumes the host model on the link and short reset completion parameters.
`timescale 1ns/100ps
module testbench;
    localparam int unsigned SLPIN = 200;
    localparam int unsigned SLPOUT = 400;
    localparam int unsigned OTPL = 100;
    logic sys_clk = 1'b0, nrst_n, rst_pin_n, sleep_out, rx_ready;
    logic [15:0] otp_data, otp_reg;
    logic clk_lp_p, clk_lp_n, clk_hs, d0_p, d0_n, d0_hs, dev_p, dev_n, dev_oe;
    logic clk_term, d0_term, rx_valid, rx_overrun, busy, blank, busy_q, busy_seen, term_seen, stall_on, dterm_seen;
    logic [7:0] rx_data;
    logic [7:0] rnd = 8'h3a;
    logic [7:0] exp_b[$];
    logic [1:0] exp_lp[$];
    int errors = 0, checks_done = 0, cycles = 0, t_fall = 0;

    dlr_top #(.DONE_SLPIN_CYC(SLPIN), .DONE_SLPOUT_CYC(SLPOUT), .OTP_LOAD_CYC(OTPL), .OTP_WIDTH(16)) uut (
        .SYS_CLK_I(sys_clk), .NRST_I(nrst_n), .RESET_IN_LOW_N_I(rst_pin_n),
        .SLEEP_OUT_I(sleep_out), .OTP_DATA_I(otp_data),
        .CLK_LANE_LP_P_I(clk_lp_p), .CLK_LANE_LP_N_I(clk_lp_n), .CLK_LANE_HS_I(clk_hs),
        .D0_LP_P_I(d0_p), .D0_LP_N_I(d0_n), .D0_HS_I(d0_hs),
        .D0_LP_P_O(dev_p), .D0_LP_N_O(dev_n), .D0_LP_OE_O(dev_oe),
        .CLK_TERM_EN_O(clk_term), .D0_TERM_EN_O(d0_term),
        .RX_VALID_O(rx_valid), .RX_READY_I(rx_ready), .RX_DATA_O(rx_data), .RX_OVERRUN_O(rx_overrun),
        .RESET_BUSY_O(busy), .BLANK_O(blank), .OTP_REG_O(otp_reg));

    dlr_host_model host (
        .clk_lp_p_o(clk_lp_p), .clk_lp_n_o(clk_lp_n), .clk_hs_o(clk_hs),
        .d0_lp_p_o(d0_p), .d0_lp_n_o(d0_n), .d0_hs_o(d0_hs),
        .dev_p_i(dev_p), .dev_n_i(dev_n), .dev_oe_i(dev_oe));

    // Next value of the pseudo-random sequence.
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // Compares a value and reports a mismatch.
    task automatic check_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
    begin
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    end
    endtask : check_val

    // Compares a flag and reports a mismatch.
    task automatic check_flag(input string nm, input logic exp, input logic got);
    begin
        check_val(nm, {15'h0000, exp}, {15'h0000, got});
    end
    endtask : check_flag

    // Prints the verdict and ends the run.
    task automatic test_done();
    begin
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask : test_done

    // Queues n random bytes for the host, of which the first keep are expected out.
    task automatic burst(input int n, input int keep, input int unsigned pad);
    begin
        for (int i = 0; i < n; i++)
        begin
            rnd = lfsr(rnd);
            host.tx_q.push_back(rnd);
            if (i < keep)
                exp_b.push_back(rnd);
        end
        host.send_burst(pad);
        @(negedge sys_clk);
    end
    endtask : burst

    // System clock, 50 ns period.
    always #25 sys_clk = ~sys_clk;

    // Random receiver stalls.
    always @(negedge sys_clk)
    begin
        if (stall_on)
        begin
            rnd = lfsr(rnd);
            rx_ready = rnd[0];
        end
    end

    // Takes the oldest note off a queue whenever a result appears; also cuts a hang short.
    always @(posedge sys_clk)
    begin
        cycles++;
        busy_q <= busy;
        if (busy_q === 1'b1 && busy === 1'b0)
            t_fall = cycles;
        if (busy === 1'b1)
            busy_seen = 1'b1;
        if (clk_term === 1'b1)
            term_seen = 1'b1;
        if (d0_term === 1'b1)
            dterm_seen = 1'b1;
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
        begin
            if (exp_b.size() == 0)
                check_flag("rx_unexpected", 1'b0, 1'b1);
            else
                check_val("rx_data", {8'h00, exp_b.pop_front()}, {8'h00, rx_data});
        end
        if (dev_oe === 1'b1)
        begin
            if (exp_lp.size() == 0)
                check_flag("lp_unexpected", 1'b0, 1'b1);
            else
                check_val("d0_lp_drive", {14'h0000, exp_lp.pop_front()}, {14'h0000, dev_p, dev_n});
        end
        if (cycles == 20000)
        begin
            errors++;
            test_done();
        end
    end

    // Main sequence.
    initial
    begin
        int lim;
        int t_rel;
        nrst_n = 1'b0;
        rst_pin_n = 1'b1;
        sleep_out = 1'b0;
        otp_data = 16'h0000;
        rx_ready = 1'b1;
        stall_on = 1'b0;
        term_seen = 1'b0;
        dterm_seen = 1'b0;
        repeat (3) @(negedge sys_clk);
        nrst_n = 1'b1;
        repeat (SLPIN - 10) @(negedge sys_clk);
        check_flag("blank", 1'b1, blank);
        repeat (20) @(negedge sys_clk);
        check_flag("busy_slpin", 1'b0, busy);
        busy_seen = 1'b0;
        rst_pin_n = 1'b0;
        repeat (dlr_pkg::RST_REJECT_CYC - 20) @(negedge sys_clk);
        rst_pin_n = 1'b1;
        repeat (120) @(negedge sys_clk);
        check_flag("busy_reject", 1'b0, busy_seen);
        stall_on = 1'b1;
        burst(3, 3, 0);
        stall_on = 1'b0;
        rx_ready = 1'b0;
        burst(4, 2, 0);
        check_flag("overrun", 1'b1, rx_overrun);
        rx_ready = 1'b1;
        burst(1, 1, 5);
        check_flag("clk_term", 1'b1, term_seen);
        check_flag("d0_term", 1'b1, dterm_seen);
        repeat (5) exp_lp.push_back(2'h0);
        exp_lp.push_back(2'h2);
        exp_lp.push_back(2'h3);
        host.turn_round();
        repeat (10) @(negedge sys_clk);
        check_val("lp_left", 16'h0000, exp_lp.size());
        for (int m = 0; m < 2; m++)
        begin
            lim = m ? SLPOUT : SLPIN;
            sleep_out = m[0];
            rnd = lfsr(rnd);
            otp_data = {rnd, ~rnd};
            rst_pin_n = 1'b0;
            repeat (150) @(negedge sys_clk);
            rst_pin_n = 1'b1;
            repeat (30) @(negedge sys_clk);
            rst_pin_n = 1'b0;
            repeat (150) @(negedge sys_clk);
            check_flag("busy_start", 1'b1, busy);
            rst_pin_n = 1'b1;
            t_rel = cycles;
            t_fall = 0;
            term_seen = 1'b0;
            dterm_seen = 1'b0;
            if (m == 1)
            begin
                host.tx_q.push_back(rnd);
                fork
                    host.send_burst(0);
                join_none
            end
            repeat (OTPL + 110) @(negedge sys_clk);
            check_val("otp_reg", otp_data, otp_reg);
            check_flag("blank", 1'b1, blank);
            check_flag("overrun", 1'b0, rx_overrun);
            repeat (lim) @(negedge sys_clk);
            check_flag("busy_end", 1'b0, busy);
            check_flag("busy_len", 1'b1, (t_fall - t_rel) >= lim);
            check_flag("term_busy", 1'b0, term_seen || dterm_seen);
        end
        check_val("rx_left", 16'h0000, exp_b.size());
        test_done();
    end
endmodule : testbench
